// File: core/xint_regs.svh
// xint_regs.svh: offsets, field positions, reset values and vector table
// assumes: included by the extended interrupt controller files only
`ifndef XINT_REGS_SVH
`define XINT_REGS_SVH

`define CTRL_ADDR      8'hC0
`define PORT_ADDR      8'hD8
`define CTRL_BIT_BASE  8'hC0
`define PORT_BIT_BASE  8'hD8

`define F_IT2          0
`define F_IE2          1
`define F_EX2          2
`define F_PX2          3
`define F_IT3          4
`define F_IE3          5
`define F_EX3          6
`define F_PX3          7

`define CTRL_RESET     8'h00
`define PORT_RESET     4'hF

`define VEC_BASE       8'h03
`define VEC_STEP       8'h08

`endif

// File: core/xint_pkg.sv
// xint_pkg.sv: types for the extended interrupt controller
// assumes: nothing beyond a SystemVerilog tool
package xint_pkg;
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_REQUEST = 2'b01,
		ST_SERVICE = 2'b10
	} arb_state_type;

	typedef logic [7:0] sfr_byte_type;
endpackage : xint_pkg

// File: core/edge_catcher.sv
// edge_catcher.sv: one external request input with pending flag
// assumes: pin is synchronous to clock, low active
`timescale 1ns/1ps
`default_nettype none
module edge_catcher (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic pin_n,
	input  wire logic edge_sel,
	input  wire logic sw_set,
	input  wire logic sw_clr,
	input  wire logic serviced,
	output var  logic flag,
	output var  logic request
);
	logic prev_ff;
	logic nxt_prev;
	logic flag_ff;
	logic nxt_flag;
	logic fall;

	// -------------------------------------------------------------
	// edge detect and pending flag
	// -------------------------------------------------------------
	always_comb begin
		fall     = prev_ff & ~pin_n;
		nxt_prev = pin_n;
		nxt_flag = flag_ff;
		if (sw_clr || (serviced && edge_sel))
			nxt_flag = 1'b0;
		if (sw_set)
			nxt_flag = 1'b1;
		if (edge_sel && fall)
			nxt_flag = 1'b1;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			prev_ff <= 1'b1;
			flag_ff <= 1'b0;
		end else begin
			prev_ff <= nxt_prev;
			flag_ff <= nxt_flag;
		end
	end

	assign flag    = flag_ff;
	assign request = edge_sel ? flag_ff : ~pin_n;

	edge_sets_flag_a: assert property (@(posedge clock) disable iff (rst)
		(edge_sel && fall) |=> flag_ff)
		else $error("edge not captured");

	service_clear_a: assert property (@(posedge clock) disable iff (rst)
		(serviced && edge_sel && !sw_set && !fall) |=> !flag_ff)
		else $error("pending not cleared on service");
endmodule : edge_catcher
`default_nettype wire

// File: core/ext_int_extra_ctrl.sv
// ext_int_extra_ctrl.sv: extra control register, nibble port and 8-source arbiter
// assumes: core drives sfr byte and bit accesses synchronous to clock
// Summary of operation
// - the extra control register sits at sfr 0C0H and is bit addressable.
// - bits 7..0 are priority, enable, pending, edge select of source 3, then the same for source 2.
// - bit address 0C2H is the source 2 enable.
// - a set priority bit puts the source at high level, clear at low level.
// - an added source only requests while its enable bit is set.
// - edge select set means falling edge, clear means low level.
// - in edge mode the pending flag is set by hardware on an edge and cleared on service.
// - the eight sources vector to 03H, 0BH, 13H, 1BH, 23H, 2BH, 33H and 3BH.
// - within one priority level sources are served in fixed order 0 to 7.
// - original sources gate with enable register bits 0..5, source 6 with extra control bit 2, source 7 with extra control bit 6.
// - external 0 and 1 take trigger type from timer control bits 0 and 2; sources 6 and 7 from extra control bits 0 and 4.
// - a bit addressable port at sfr 0D8H implements bits 3..0 like port 1.
// - the upper two port pins also serve as the added interrupt inputs.
// - the port resets to all ones.
`timescale 1ns/1ps
`default_nettype none
`include "xint_regs.svh"
module ext_int_extra_ctrl (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic [7:0]        sfr_addr,
	input  wire xint_pkg::sfr_byte_type sfr_wdata,
	input  wire logic              sfr_wr,
	input  wire logic              sfr_rd,
	input  wire logic [7:0]        bit_addr,
	input  wire logic              bit_wr,
	input  wire logic              bit_val,
	input  wire logic [7:0]        interrupt_enable_reg,
	input  wire logic [7:0]        timer_control_reg,
	input  wire logic [5:0]        core_requests,
	input  wire logic [5:0]        core_prio_high,
	input  wire logic              int_ack,
	input  wire logic [3:0]        nibble_port_in,
	output var  xint_pkg::sfr_byte_type sfr_rdata,
	output var  logic              int_req,
	output var  logic [7:0]        int_vector,
	output var  logic [2:0]        int_source,
	output var  logic              int_high,
	output var  logic [3:0]        nibble_port_out,
	output var  logic [3:0]        nibble_port_oe,
	output var  logic              ext0_edge_mode,
	output var  logic              ext1_edge_mode
);
	import xint_pkg::*;

	// -------------------------------------------------------------
	// registers
	// -------------------------------------------------------------
	logic [7:0]    ctrl_ff, nxt_ctrl;
	logic [3:0]    port_ff, nxt_port;
	sfr_byte_type  rdata_ff, nxt_rdata;
	arb_state_type state_ff, nxt_state;
	logic [2:0]    src_ff, nxt_src;
	logic          high_ff, nxt_high;
	logic          req_ff, nxt_req;
	logic [7:0]    vec_ff, nxt_vec;
	logic          e0_ff, e1_ff;

	logic          flag2, flag3, rq2, rq3;
	logic          set2, clr2, set3, clr3;
	logic          svc2, svc3;
	logic [7:0]    pend, gate, prio;
	logic [7:0]    hi_req, lo_req;
	logic          found;
	logic [2:0]    pick;
	logic          pick_hi;

	wire ctrl_byte = sfr_wr && (sfr_addr == `CTRL_ADDR);
	wire port_byte = sfr_wr && (sfr_addr == `PORT_ADDR);
	wire ctrl_bit  = bit_wr && (bit_addr[7:3] == 5'(`CTRL_BIT_BASE >> 3));
	wire port_bit  = bit_wr && (bit_addr[7:3] == 5'(`PORT_BIT_BASE >> 3)) && !bit_addr[2];

	always_comb begin
		set2 = (ctrl_byte && sfr_wdata[`F_IE2]) || (ctrl_bit && bit_addr[2:0] == 3'd`F_IE2 && bit_val);
		clr2 = (ctrl_byte && !sfr_wdata[`F_IE2]) || (ctrl_bit && bit_addr[2:0] == 3'd`F_IE2 && !bit_val);
		set3 = (ctrl_byte && sfr_wdata[`F_IE3]) || (ctrl_bit && bit_addr[2:0] == 3'd`F_IE3 && bit_val);
		clr3 = (ctrl_byte && !sfr_wdata[`F_IE3]) || (ctrl_bit && bit_addr[2:0] == 3'd`F_IE3 && !bit_val);
		svc2 = int_ack && state_ff == ST_REQUEST && src_ff == 3'd6;
		svc3 = int_ack && state_ff == ST_REQUEST && src_ff == 3'd7;
	end

	// -------------------------------------------------------------
	// added external sources, pins shared with the nibble port
	// -------------------------------------------------------------
	edge_catcher u_src2 (
		.clock    (clock),
		.rst      (rst),
		.pin_n    (nibble_port_in[2] & port_ff[2]),
		.edge_sel (ctrl_ff[`F_IT2]),
		.sw_set   (set2),
		.sw_clr   (clr2),
		.serviced (svc2),
		.flag     (flag2),
		.request  (rq2)
	);

	edge_catcher u_src3 (
		.clock    (clock),
		.rst      (rst),
		.pin_n    (nibble_port_in[3] & port_ff[3]),
		.edge_sel (ctrl_ff[`F_IT3]),
		.sw_set   (set3),
		.sw_clr   (clr3),
		.serviced (svc3),
		.flag     (flag3),
		.request  (rq3)
	);

	// -------------------------------------------------------------
	// control register and port
	// -------------------------------------------------------------
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_port = port_ff;
		if (ctrl_byte)
			nxt_ctrl = sfr_wdata;
		if (ctrl_bit)
			nxt_ctrl[bit_addr[2:0]] = bit_val;
		nxt_ctrl[`F_IE2] = flag2;
		nxt_ctrl[`F_IE3] = flag3;
		if (port_byte)
			nxt_port = sfr_wdata[3:0];
		if (port_bit)
			nxt_port[bit_addr[1:0]] = bit_val;
		nxt_rdata = rdata_ff;
		if (sfr_rd) begin
			case (sfr_addr)
				`CTRL_ADDR: nxt_rdata = {ctrl_ff[7:6], flag3, ctrl_ff[4:2], flag2, ctrl_ff[0]};
				`PORT_ADDR: nxt_rdata = {4'h0, nibble_port_in};
				default:    nxt_rdata = 8'h00;
			endcase
		end
	end

	// -------------------------------------------------------------
	// source table and arbitration
	// -------------------------------------------------------------
	always_comb begin
		pend = {rq3, rq2, core_requests};
		gate = {ctrl_ff[`F_EX3], ctrl_ff[`F_EX2], interrupt_enable_reg[5:0]};
		prio = {ctrl_ff[`F_PX3], ctrl_ff[`F_PX2], core_prio_high};
		hi_req = pend & gate & prio & {8{interrupt_enable_reg[7]}};
		lo_req = pend & gate & ~prio & {8{interrupt_enable_reg[7]}};
		found = 1'b0;
		pick = 3'd0;
		pick_hi = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (lo_req[i]) begin
				found = 1'b1;
				pick = 3'(i);
			end
		end
		for (int i = 7; i >= 0; i--) begin
			if (hi_req[i]) begin
				pick_hi = 1'b1;
				pick = 3'(i);
			end
		end
		found = found | pick_hi;

		nxt_state = state_ff;
		nxt_src = src_ff;
		nxt_high = high_ff;
		nxt_req = req_ff;
		nxt_vec = vec_ff;
		case (state_ff)
			ST_IDLE: begin
				if (found) begin
					nxt_state = ST_REQUEST;
					nxt_src = pick;
					nxt_high = pick_hi;
					nxt_req = 1'b1;
					nxt_vec = `VEC_BASE + {2'b00, pick, 3'b000};
				end
			end
			ST_REQUEST: begin
				if (int_ack) begin
					nxt_state = ST_SERVICE;
					nxt_req = 1'b0;
				end
			end
			ST_SERVICE: begin
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_req = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			ctrl_ff  <= `CTRL_RESET;
			port_ff  <= `PORT_RESET;
			rdata_ff <= 8'h00;
			state_ff <= ST_IDLE;
			src_ff   <= 3'h0;
			high_ff  <= 1'b0;
			req_ff   <= 1'b0;
			vec_ff   <= 8'h00;
			e0_ff    <= 1'b0;
			e1_ff    <= 1'b0;
		end else begin
			ctrl_ff  <= nxt_ctrl;
			port_ff  <= nxt_port;
			rdata_ff <= nxt_rdata;
			state_ff <= nxt_state;
			src_ff   <= nxt_src;
			high_ff  <= nxt_high;
			req_ff   <= nxt_req;
			vec_ff   <= nxt_vec;
			e0_ff    <= timer_control_reg[0];
			e1_ff    <= timer_control_reg[2];
		end
	end

	always_comb begin
		sfr_rdata       = rdata_ff;
		int_req         = req_ff;
		int_vector      = vec_ff;
		int_source      = src_ff;
		int_high        = high_ff;
		nibble_port_out = port_ff;
		nibble_port_oe  = ~port_ff; // quasi bidirectional: drive low only
		ext0_edge_mode  = e0_ff;
		ext1_edge_mode  = e1_ff;
	end

	// -------------------------------------------------------------
	// checks
	// -------------------------------------------------------------
	vector_map_a: assert property (@(posedge clock) disable iff (rst)
		req_ff |-> vec_ff == `VEC_BASE + {2'b00, src_ff, 3'b000})
		else $error("vector does not match source");
	disabled_src2_a: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_IDLE && found && !ctrl_ff[`F_EX2]) |=> src_ff != 3'd6)
		else $error("disabled source 2 taken");
	high_wins_a: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_IDLE && |hi_req) |=> high_ff)
		else $error("high level not preferred");
	bit_enable_a: assert property (@(posedge clock) disable iff (rst)
		(bit_wr && bit_addr == 8'hC2 && bit_val) |=> ctrl_ff[`F_EX2])
		else $error("bit set of source 2 enable lost");
	port_reset_a: assert property (@(posedge clock)
		rst |=> port_ff == `PORT_RESET && ctrl_ff == `CTRL_RESET)
		else $error("reset values wrong");
	order_low_a: assert property (@(posedge clock) disable iff (rst)
		(state_ff == ST_IDLE && hi_req == 8'h00 && lo_req[0]) |=> src_ff == 3'd0)
		else $error("polling order broken");
	edge_mode_a: assert property (@(posedge clock) disable iff (rst)
		1'b1 |=> ext0_edge_mode == $past(timer_control_reg[0]))
		else $error("external 0 trigger type wrong");
endmodule : ext_int_extra_ctrl
`default_nettype wire

// File: verification/core_ack_model.sv
// core_ack_model.sv: processor core side that takes interrupt requests
// assumes: design outputs settle before the falling edge of clock
`timescale 1ns/1ps
`default_nettype none
module core_ack_model (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [3:0] ack_delay,
	input  wire logic       int_req,
	input  wire logic [7:0] int_vector,
	input  wire logic [2:0] int_source,
	input  wire logic       int_high,
	output var  logic       int_ack,
	output var  logic [7:0] ack_count,
	output var  logic [7:0] last_vector,
	output var  logic [3:0] last_info
);
	logic [3:0] wait_ff;
	logic       armed_ff;
	// ----------------------------------------------------------------
	// one ack pulse once a request has stood ack_delay cycles
	// ----------------------------------------------------------------
	always @(negedge clock) begin
		int_ack <= 1'b0;
		if (rst) begin
			armed_ff  <= 1'b1;
			wait_ff   <= 4'h0;
			ack_count <= 8'h00;
		end else if (!int_req) begin
			armed_ff <= 1'b1;
			wait_ff  <= 4'h0;
		end else if (armed_ff && wait_ff == ack_delay) begin
			int_ack     <= 1'b1;
			armed_ff    <= 1'b0;
			ack_count   <= ack_count + 8'h01;
			last_vector <= int_vector;
			last_info   <= {int_high, int_source};
		end else if (armed_ff) begin
			wait_ff <= wait_ff + 4'h1;
		end
	end
endmodule : core_ack_model
`default_nettype wire

// File: verification/ext_int_extra_ctrl_test.sv
// ext_int_extra_ctrl_test.sv: self-checking bench for the extended interrupt controller
// assumes: core_ack_model stands in for the processor core
`timescale 1ns/1ps
`default_nettype none
module ext_int_extra_ctrl_test;
	import xint_pkg::*;
	logic clock, rst, sfr_wr, sfr_rd, bit_wr, bit_val, int_ack, int_req, int_high;
	logic ext0_edge_mode, ext1_edge_mode;
	logic [7:0] sfr_addr, bit_addr, interrupt_enable_reg, timer_control_reg, int_vector;
	logic [7:0] ack_count, last_vector, r;
	logic [5:0] core_requests, core_prio_high;
	logic [3:0] nibble_port_in, nibble_port_out, nibble_port_oe, ack_delay, last_info;
	logic [2:0] int_source;
	sfr_byte_type sfr_wdata, sfr_rdata;
	int miscompares = 0;
	int num_checks = 0;
	int i;
	logic [7:0] base;
	ext_int_extra_ctrl ext_int_extra_ctrl_inst (.clock, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.bit_addr, .bit_wr, .bit_val, .interrupt_enable_reg, .timer_control_reg, .core_requests,
		.core_prio_high, .int_ack, .nibble_port_in, .sfr_rdata, .int_req, .int_vector, .int_source,
		.int_high, .nibble_port_out, .nibble_port_oe, .ext0_edge_mode, .ext1_edge_mode);
	core_ack_model core_ack_model_inst (.clock, .rst, .ack_delay, .int_req, .int_vector, .int_source,
		.int_high, .int_ack, .ack_count, .last_vector, .last_info);
	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
		@(negedge clock) sfr_wr = 1'b0;
		@(negedge clock);
	endtask : wr
	task bw(input logic [7:0] a, input logic v);
		bit_addr = a; bit_val = v; bit_wr = 1'b1;
		@(negedge clock) bit_wr = 1'b0;
		@(negedge clock);
	endtask : bw
	task rd(input logic [7:0] a, output logic [7:0] d);
		sfr_addr = a; sfr_rd = 1'b1;
		@(negedge clock) sfr_rd = 1'b0;
		@(negedge clock) d = sfr_rdata;
	endtask : rd
	task idle(input int n);
		repeat (n) @(negedge clock);
	endtask : idle
	task expect_int(input logic [7:0] v, input logic [3:0] info);
		for (int k = 0; k < 30 && ack_count === base; k++) @(negedge clock);
		chk(ack_count, base + 8'h01);
		chk(last_vector, v);
		chk({4'h0, last_info}, {4'h0, info});
		base = ack_count;
	endtask : expect_int
	task print_verdict;
		if (miscompares == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : print_verdict
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		repeat (6000) @(posedge clock);
		miscompares++;
		print_verdict;
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rst = 1'b1; sfr_addr = 8'h00; sfr_wdata = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0;
		bit_addr = 8'h00; bit_wr = 1'b0; bit_val = 1'b0; interrupt_enable_reg = 8'h00;
		timer_control_reg = 8'h00; core_requests = 6'h00; core_prio_high = 6'h20;
		nibble_port_in = 4'hF; ack_delay = 4'h0;
		idle(2);
		rst = 1'b0;
		rd(8'hC0, r); chk(r, 8'h00);
		chk({4'h0, nibble_port_out}, 8'h0F);
		wr(8'hC0, 8'hA5); rd(8'hC0, r); chk(r, 8'hA5);
		bw(8'hC7, 1'b0); bw(8'hC5, 1'b0); rd(8'hC0, r); chk(r, 8'h05);
		wr(8'hC0, 8'h00); bw(8'hC2, 1'b1); rd(8'hC0, r); chk(r, 8'h04);
		wr(8'hC0, 8'h05); interrupt_enable_reg = 8'h80; ack_delay = 4'hA; base = ack_count;
		nibble_port_in = 4'hB; idle(2);
		rd(8'hC0, r); chk(r, 8'h07);
		expect_int(8'h33, 4'h6);
		idle(3); rd(8'hC0, r); chk(r, 8'h05);
		idle(10); chk(ack_count, base);
		nibble_port_in = 4'hF; ack_delay = 4'h0;
		wr(8'hC0, 8'h50); nibble_port_in = 4'h7;
		expect_int(8'h3B, 4'h7);
		nibble_port_in = 4'hF; idle(3); rd(8'hC0, r); chk(r, 8'h50);
		wr(8'hC0, 8'h40); nibble_port_in = 4'h7; expect_int(8'h3B, 4'h7);
		nibble_port_in = 4'hF; idle(4); base = ack_count;
		wr(8'hC0, 8'h00); nibble_port_in = 4'h7; idle(12); chk(ack_count, base);
		nibble_port_in = 4'hF;
		interrupt_enable_reg = 8'h81; wr(8'hC0, 8'h0C); core_requests = 6'h01; nibble_port_in = 4'hB;
		expect_int(8'h33, 4'hE);
		nibble_port_in = 4'hF; expect_int(8'h03, 4'h0);
		wr(8'hC0, 8'h04); nibble_port_in = 4'hB; idle(4); base = ack_count;
		expect_int(8'h03, 4'h0);
		core_requests = 6'h00; expect_int(8'h33, 4'h6);
		nibble_port_in = 4'hF; wr(8'hC0, 8'h00); idle(4); base = ack_count;
		for (i = 0; i < 6; i++) begin
			interrupt_enable_reg = 8'h80 | (8'h01 << i); core_requests = 6'h01 << i;
			expect_int(8'h03 + 8'h08 * i[7:0], {i == 5, i[2:0]});
			core_requests = 6'h00; idle(4); base = ack_count;
		end
		interrupt_enable_reg = 8'h80; core_requests = 6'h3F; idle(12); chk(ack_count, base);
		core_requests = 6'h00;
		timer_control_reg = 8'h01; idle(2); chk({6'h00, ext1_edge_mode, ext0_edge_mode}, 8'h01);
		timer_control_reg = 8'h04; idle(2); chk({6'h00, ext1_edge_mode, ext0_edge_mode}, 8'h02);
		wr(8'hD8, 8'h0A); chk({nibble_port_oe, nibble_port_out}, 8'h5A);
		bw(8'hD8, 1'b1); bw(8'hD9, 1'b0); chk({nibble_port_oe, nibble_port_out}, 8'h69);
		nibble_port_in = 4'h6; rd(8'hD8, r); chk({4'h0, r[3:0]}, 8'h06);
		nibble_port_in = 4'hF; idle(2); base = ack_count;
		wr(8'hC0, 8'h04); expect_int(8'h33, 4'h6);
		wr(8'hC0, 8'h00); bw(8'hDA, 1'b1); idle(4);
		print_verdict;
	end
endmodule : ext_int_extra_ctrl_test
`default_nettype wire
